// ===== rcx_pkg.sv
// Purpose: Constants and types for the radio coexistence arbitration block
// Assumes: 20 MHz clock, AXI4-Lite register access
`default_nettype none
package rcx_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_TMO = 4'h4;
  localparam logic [3:0] OFS_PULSE = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hc;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int US_NS = 1000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
  localparam logic [7:0] TMO_RST = 8'h10;
  localparam logic [7:0] PULSE_RST = 8'h14;
  localparam logic [7:0] PULSE_MIN = 8'h01;
  localparam logic [7:0] PULSE_MAX = 8'hfe;
  typedef struct packed {
    logic dir_en;
    logic pri_en;
    logic pwm_pri;
    logic tx_hi;
    logic rx_hi;
    logic retry_hi;
    logic retry_en;
    logic ack_gate;
    logic shared;
    logic act_hi;
  } rcx_ctrl_t;
  localparam rcx_ctrl_t CTRL_RST = 10'h000;
  typedef enum logic [1:0] {DP_IDLE, DP_PULSE, DP_STATE} rcx_dir_t;
endpackage
`default_nettype wire

// ===== rcx_top.sv
// Purpose: Coexistence request, priority, retry hold and ACK gating
// Assumes: Radio inputs are on clk_i; pins are asynchronous
// Notes: Two-way pins use separate in, out and enable signals
`default_nettype none
module rcx_top #(
  parameter int MS_CYC = rcx_pkg::MS_CYCLES
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic radio_req_i,
  input wire logic radio_tx_i,
  input wire logic rx_low_noise_amp_enable_i,
  input wire logic pwm_req_i,
  input wire logic rx_done_i,
  input wire logic rx_crc_ok_i,
  input wire logic rx_ack_req_i,
  input wire logic grant_pin_i,
  input wire logic radio_hold_off_pin_i,
  input wire logic req_pin_i,
  output logic req_pin_o,
  output logic req_pin_oe_o,
  output logic pwm_req_pin_o,
  output logic pwm_req_pin_oe_o,
  output logic pri_pin_o,
  output logic dir_pri_pin_o,
  output logic dir_pri_pin_oe_o,
  output logic ack_send_o
);
  localparam int US_CYC = rcx_pkg::US_CYCLES;

  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  logic aw_hold_ff, nxt_aw_hold, w_hold_ff, nxt_w_hold;
  logic [3:0] aw_addr_ff, nxt_aw_addr, wstrb_ff, nxt_wstrb;
  logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic awrdy_ff, nxt_awrdy, wrdy_ff, nxt_wrdy, ardy_ff, nxt_ardy;
  logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  rcx_pkg::rcx_ctrl_t ctrl_ff, nxt_ctrl;
  logic [7:0] tmo_ff, nxt_tmo, pulse_ff, nxt_pulse;

  logic [2:0] sync1_ff, sync2_ff;
  logic grant, radio_hold_off, line_act;
  logic hold_ff, nxt_hold;
  logic [7:0] hold_cnt_ff, nxt_hold_cnt;
  logic [14:0] ms_cnt_ff, nxt_ms_cnt;
  logic [4:0] us_cnt_ff, nxt_us_cnt;
  logic [7:0] pul_cnt_ff, nxt_pul_cnt;
  rcx_pkg::rcx_dir_t dir_st_ff, nxt_dir_st;
  logic req_ff, nxt_req, secured_ff, nxt_secured, reqd_ff, nxt_reqd;
  logic pri_ff, nxt_pri, pri_lat_ff, nxt_pri_lat;
  logic req_o_ff, nxt_req_o, req_oe_ff, nxt_req_oe;
  logic pwm_o_ff, nxt_pwm_o, pwm_oe_ff, nxt_pwm_oe, spri_ff, nxt_spri;
  logic dir_o_ff, nxt_dir_o, dir_oe_ff, nxt_dir_oe, ack_ff, nxt_ack;
  logic req_any, req_cmb, dir_act, dir_line, start_hold, ms_tick, us_tick;

  // Register bus: address and data may arrive in either order
  always_comb begin
    nxt_aw_hold = aw_hold_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_hold = w_hold_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    nxt_ctrl = ctrl_ff;
    nxt_tmo = tmo_ff;
    nxt_pulse = pulse_ff;
    if (s_axi_awvalid_i && awrdy_ff) begin
      nxt_aw_hold = 1'b1;
      nxt_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && wrdy_ff) begin
      nxt_w_hold = 1'b1;
      nxt_wdata = s_axi_wdata_i;
      nxt_wstrb = s_axi_wstrb_i;
    end
    if (bvalid_ff && s_axi_bready_i) begin
      nxt_bvalid = 1'b0;
    end
    if (aw_hold_ff && w_hold_ff && !bvalid_ff) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = rcx_pkg::RESP_OKAY;
      unique case (aw_addr_ff)
        rcx_pkg::OFS_CTRL: begin
          if (wstrb_ff[0]) nxt_ctrl[7:0] = wdata_ff[7:0];
          if (wstrb_ff[1]) nxt_ctrl[9:8] = wdata_ff[9:8];
        end
        rcx_pkg::OFS_TMO: begin
          if (wstrb_ff[0]) nxt_tmo = wdata_ff[7:0];
        end
        rcx_pkg::OFS_PULSE: begin
          if (wstrb_ff[0]) begin
            nxt_pulse = wdata_ff[7:0];
            if (wdata_ff[7:0] < rcx_pkg::PULSE_MIN) begin
              nxt_pulse = rcx_pkg::PULSE_MIN;
            end
            if (wdata_ff[7:0] > rcx_pkg::PULSE_MAX) begin
              nxt_pulse = rcx_pkg::PULSE_MAX;
            end
          end
        end
        rcx_pkg::OFS_STAT: nxt_bresp = rcx_pkg::RESP_OKAY;
        default: nxt_bresp = rcx_pkg::RESP_SLVERR;
      endcase
    end
    if (rvalid_ff && s_axi_rready_i) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && ardy_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = rcx_pkg::RESP_OKAY;
      unique case (s_axi_araddr_i)
        rcx_pkg::OFS_CTRL: nxt_rdata = {22'h0, ctrl_ff};
        rcx_pkg::OFS_TMO: nxt_rdata = {24'h0, tmo_ff};
        rcx_pkg::OFS_PULSE: nxt_rdata = {24'h0, pulse_ff};
        rcx_pkg::OFS_STAT: nxt_rdata = {16'h0, hold_cnt_ff, 1'b0,
          dir_st_ff, radio_hold_off, grant, secured_ff, req_ff, hold_ff};
        default: begin
          nxt_rdata = 32'h0;
          nxt_rresp = rcx_pkg::RESP_SLVERR;
        end
      endcase
    end
    nxt_awrdy = !nxt_aw_hold && !nxt_bvalid;
    nxt_wrdy = !nxt_w_hold && !nxt_bvalid;
    nxt_ardy = !nxt_rvalid;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= 4'h0;
      w_hold_ff <= 1'b0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      awrdy_ff <= 1'b0;
      wrdy_ff <= 1'b0;
      ardy_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      rvalid_ff <= 1'b0;
      rresp_ff <= 2'h0;
      rdata_ff <= 32'h0;
      ctrl_ff <= rcx_pkg::CTRL_RST;
      tmo_ff <= rcx_pkg::TMO_RST;
      pulse_ff <= rcx_pkg::PULSE_RST;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      aw_addr_ff <= nxt_aw_addr;
      w_hold_ff <= nxt_w_hold;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      awrdy_ff <= nxt_awrdy;
      wrdy_ff <= nxt_wrdy;
      ardy_ff <= nxt_ardy;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      ctrl_ff <= nxt_ctrl;
      tmo_ff <= nxt_tmo;
      pulse_ff <= nxt_pulse;
    end
  end

  // Pins are asynchronous: two flops before use
  assign grant = (sync2_ff[0] == ctrl_ff.act_hi);
  assign radio_hold_off = (sync2_ff[1] == ctrl_ff.act_hi);
  assign line_act = (sync2_ff[2] == ctrl_ff.act_hi);
  assign req_any = radio_req_i | hold_ff;
  assign req_cmb = req_any | pwm_req_i;
  assign dir_act = ctrl_ff.dir_en & ctrl_ff.pri_en;
  assign ms_tick = (ms_cnt_ff == 15'(MS_CYC - 1));
  assign us_tick = (us_cnt_ff == 5'(US_CYC - 1));
  // Good packet without grant also starts the hold
  assign start_hold = rx_done_i & ctrl_ff.retry_en & (tmo_ff != 8'h00) &
    (!rx_crc_ok_i | !grant);
  // Pulse follows the priority polarity; radio state is a plain level,
  // high while transmitting, low while the LNA is on
  assign dir_line = (dir_st_ff == rcx_pkg::DP_PULSE) ?
    (pri_lat_ff ^ !ctrl_ff.act_hi) :
    (radio_tx_i & !rx_low_noise_amp_enable_i);

  always_comb begin
    nxt_hold = hold_ff;
    nxt_hold_cnt = hold_cnt_ff;
    nxt_ms_cnt = ms_tick ? 15'h0 : ms_cnt_ff + 15'h1;
    nxt_us_cnt = us_tick ? 5'h0 : us_cnt_ff + 5'h1;
    nxt_pul_cnt = pul_cnt_ff;
    nxt_dir_st = dir_st_ff;
    nxt_pri_lat = pri_lat_ff;
    if (start_hold) begin
      nxt_hold = 1'b1;
      nxt_hold_cnt = tmo_ff;
      nxt_ms_cnt = 15'h0;
    end else if (rx_done_i || !ctrl_ff.retry_en) begin
      nxt_hold = 1'b0;
      nxt_hold_cnt = 8'h00;
    end else if (hold_ff && ms_tick) begin
      nxt_hold_cnt = hold_cnt_ff - 8'h01;
      if (hold_cnt_ff == 8'h01) nxt_hold = 1'b0;
    end
    // Hold wins over normal priority so the retry keeps its level
    if (hold_ff) begin
      nxt_pri = ctrl_ff.pri_en & ctrl_ff.retry_hi;
    end else begin
      nxt_pri = ctrl_ff.pri_en & ((pwm_req_i & ctrl_ff.pwm_pri) |
        (radio_req_i & (radio_tx_i ? ctrl_ff.tx_hi : ctrl_ff.rx_hi)));
    end
    unique case (dir_st_ff)
      rcx_pkg::DP_IDLE: begin
        if (dir_act && req_cmb && !reqd_ff) begin
          nxt_dir_st = rcx_pkg::DP_PULSE;
          // This cycle's priority; the register still holds the idle one
          nxt_pri_lat = nxt_pri;
          nxt_pul_cnt = pulse_ff;
          nxt_us_cnt = 5'h0;
        end
      end
      rcx_pkg::DP_PULSE: begin
        if (us_tick) nxt_pul_cnt = pul_cnt_ff - 8'h01;
        if (us_tick && pul_cnt_ff == 8'h01) nxt_dir_st = rcx_pkg::DP_STATE;
        if (!dir_act) nxt_dir_st = rcx_pkg::DP_IDLE;
      end
      rcx_pkg::DP_STATE: begin
        if (!dir_act || !req_cmb) nxt_dir_st = rcx_pkg::DP_IDLE;
      end
    endcase
    nxt_req = req_any;
    nxt_reqd = req_cmb;
    // Secured when no other radio held the shared line as we raised ours
    nxt_secured = req_any & (secured_ff | (!req_ff & !line_act));
    // Shared lines drive only the active level
    nxt_req_o = ctrl_ff.shared ? ctrl_ff.act_hi : req_ff ^ !ctrl_ff.act_hi;
    nxt_req_oe = ctrl_ff.shared ? req_ff : 1'b1;
    nxt_pwm_o = ctrl_ff.shared ? ctrl_ff.act_hi :
      pwm_req_i ^ !ctrl_ff.act_hi;
    nxt_pwm_oe = ctrl_ff.shared ? pwm_req_i : 1'b1;
    // Static level during request unless directional owns it
    nxt_spri = (pri_ff & req_cmb & !dir_act) ^ !ctrl_ff.act_hi;
    // Dedicated directional pin, idle when function is off
    if (dir_st_ff == rcx_pkg::DP_IDLE) begin
      nxt_dir_o = !ctrl_ff.act_hi;
      nxt_dir_oe = !ctrl_ff.shared & dir_act;
    end else begin
      nxt_dir_o = ctrl_ff.shared ? ctrl_ff.act_hi : dir_line;
      // Shared line: drive only when the wanted level is the active one
      nxt_dir_oe = ctrl_ff.shared ? (dir_line == ctrl_ff.act_hi) :
        1'b1;
    end
    nxt_ack = rx_done_i & rx_crc_ok_i & rx_ack_req_i &
      !(ctrl_ff.ack_gate & (!grant | radio_hold_off |
      (ctrl_ff.shared & !secured_ff)));
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      hold_ff <= 1'b0;
      hold_cnt_ff <= 8'h00;
      ms_cnt_ff <= 15'h0;
      us_cnt_ff <= 5'h0;
      pul_cnt_ff <= 8'h00;
      dir_st_ff <= rcx_pkg::DP_IDLE;
      pri_lat_ff <= 1'b0;
      pri_ff <= 1'b0;
      req_ff <= 1'b0;
      reqd_ff <= 1'b0;
      secured_ff <= 1'b0;
      req_o_ff <= 1'b1;
      req_oe_ff <= 1'b0;
      pwm_o_ff <= 1'b1;
      pwm_oe_ff <= 1'b0;
      spri_ff <= 1'b1;
      dir_o_ff <= 1'b1;
      dir_oe_ff <= 1'b0;
      ack_ff <= 1'b0;
    end else begin
      sync1_ff <= {req_pin_i, radio_hold_off_pin_i, grant_pin_i};
      sync2_ff <= sync1_ff;
      hold_ff <= nxt_hold;
      hold_cnt_ff <= nxt_hold_cnt;
      ms_cnt_ff <= nxt_ms_cnt;
      us_cnt_ff <= nxt_us_cnt;
      pul_cnt_ff <= nxt_pul_cnt;
      dir_st_ff <= nxt_dir_st;
      pri_lat_ff <= nxt_pri_lat;
      pri_ff <= nxt_pri;
      req_ff <= nxt_req;
      reqd_ff <= nxt_reqd;
      secured_ff <= nxt_secured;
      req_o_ff <= nxt_req_o;
      req_oe_ff <= nxt_req_oe;
      pwm_o_ff <= nxt_pwm_o;
      pwm_oe_ff <= nxt_pwm_oe;
      spri_ff <= nxt_spri;
      dir_o_ff <= nxt_dir_o;
      dir_oe_ff <= nxt_dir_oe;
      ack_ff <= nxt_ack;
    end
  end

  assign s_axi_awready_o = awrdy_ff;
  assign s_axi_wready_o = wrdy_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_arready_o = ardy_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign req_pin_o = req_o_ff;
  assign req_pin_oe_o = req_oe_ff;
  assign pwm_req_pin_o = pwm_o_ff;
  assign pwm_req_pin_oe_o = pwm_oe_ff;
  assign pri_pin_o = spri_ff;
  assign dir_pri_pin_o = dir_o_ff;
  assign dir_pri_pin_oe_o = dir_oe_ff;
  assign ack_send_o = ack_ff;

  sequence seq_pulse_start;
    dir_st_ff == rcx_pkg::DP_IDLE && dir_act && req_cmb && !reqd_ff;
  endsequence
  // Pulse must carry the priority of the request that opened it
  sequence seq_pulse_run;
    dir_st_ff == rcx_pkg::DP_PULSE && pri_lat_ff == pri_ff ##1
      dir_o_ff == (ctrl_ff.shared ? ctrl_ff.act_hi :
      (pri_lat_ff ^ !ctrl_ff.act_hi));
  endsequence

  hold_corrupt_a: assert property (
    rx_done_i && !rx_crc_ok_i && ctrl_ff.retry_en && tmo_ff != 8'h00
    |=> hold_ff ##1 req_ff) else $error("hold not started");
  hold_denied_a: assert property (
    start_hold && rx_crc_ok_i |=> hold_ff && hold_cnt_ff == $past(tmo_ff))
    else $error("denied packet hold wrong");
  hold_off_a: assert property (
    !ctrl_ff.retry_en |=> !hold_ff) else $error("hold while disabled");
  retry_hi_a: assert property (
    hold_ff && ctrl_ff.pri_en && ctrl_ff.retry_hi |=> pri_ff)
    else $error("no priority in hold");
  retry_lo_a: assert property (
    hold_ff && !ctrl_ff.retry_hi |=> !pri_ff)
    else $error("priority in hold");
  ack_gated_a: assert property (
    rx_done_i && ctrl_ff.ack_gate &&
    (!grant || radio_hold_off || (ctrl_ff.shared && !secured_ff))
    |=> !ack_send_o) else $error("ack not suppressed");
  ack_free_a: assert property (
    rx_done_i && rx_crc_ok_i && rx_ack_req_i && !ctrl_ff.ack_gate
    |=> ack_send_o) else $error("ack missing");
  dir_pulse_a: assert property (
    seq_pulse_start |=> seq_pulse_run) else $error("no priority pulse");
  static_int_a: assert property (
    dir_act ##1 dir_act |=> spri_ff != ctrl_ff.act_hi)
    else $error("static priority leaked");
endmodule
`default_nettype wire

// ===== rcx_pta_model.sv
// Purpose: Far-side model: Wi-Fi arbiter grant and hold-off, sibling radio
// Assumes: One polarity for every line, as the block is configured
// Notes: Shared request wire is resolved here with its pull resistor
`default_nettype none
module rcx_pta_model #(
  parameter int MS_CYC = 20
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic act_hi_i,
  input wire logic [7:0] tmo_ms_i,
  input wire logic grant_cmd_i,
  input wire logic rho_cmd_i,
  input wire logic sib_req_i,
  input wire logic req_o_i,
  input wire logic req_oe_i,
  output logic grant_pin_o,
  output logic rho_pin_o,
  output logic req_wire_o
);
  int held_ff;
  int limit;
  logic grant_on;
  assign limit = (int'(tmo_ms_i) + 6) * MS_CYC;
  // Grant is capped so a radio stuck in request cannot hold the band
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !grant_cmd_i) begin
      held_ff <= 0;
    end else if (held_ff < limit) begin
      held_ff <= held_ff + 1;
    end
  end
  assign grant_on = grant_cmd_i && (held_ff < limit);
  // Same grant line reaches every radio; pushed both ways by the arbiter
  assign grant_pin_o = grant_on ~^ act_hi_i;
  assign rho_pin_o = rho_cmd_i ~^ act_hi_i;
  // Sibling only pulls to the active level; otherwise our driver wins while enabled, else the pull
  assign req_wire_o = sib_req_i ? act_hi_i :
                      (req_oe_i ? req_o_i : !act_hi_i);
endmodule
`default_nettype wire

// ===== testbench.sv
// Purpose: Self-checking bench for the coexistence arbitration block
// Assumes: 1 ms scaled to 20 cycles through MS_CYC
// Notes: Bus results are checked from a queue at the falling edge
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MSC = 20;
  localparam logic [9:0] DIR = 10'h200, PRI = 10'h100, PWMP = 10'h080;
  localparam logic [9:0] TXHI = 10'h040, RTHI = 10'h010, RTEN = 10'h008;
  localparam logic [9:0] GATE = 10'h004, SHR = 10'h002;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic radio_req = 1'b0, radio_tx = 1'b0, lna = 1'b0, pwm_req = 1'b0;
  logic rx_done = 1'b0, crc_ok = 1'b0, ack_req = 1'b0;
  logic act_hi = 1'b0, grant_cmd = 1'b0, rho_cmd = 1'b0, sib_req = 1'b0;
  logic grant_pin, rho_pin, req_wire, req_o, req_oe, pwm_o, pwm_oe;
  logic pri_o, dir_o, dir_oe, ack_send;
  logic [7:0] tmo = 8'h10;
  logic [33:0] exp_q[$];
  int miscompares = 0;
  int n_compared = 0;
  int n_ack = 0;
  int a0;
  logic [6:0] row;
  // Rows: shared, request, gate, grant, hold-off, crc good, ack expected
  localparam logic [6:0] ROWS [7] = '{7'h12, 7'h1b, 7'h1e, 7'h07, 7'h08,
    7'h7b, 7'h5a};
  always #25 clk = ~clk;
  rcx_top #(.MS_CYC(MSC)) u_dut (.clk_i(clk), .sys_rst_i(rst),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .radio_req_i(radio_req), .radio_tx_i(radio_tx),
    .rx_low_noise_amp_enable_i(lna), .pwm_req_i(pwm_req),
    .rx_done_i(rx_done), .rx_crc_ok_i(crc_ok), .rx_ack_req_i(ack_req),
    .grant_pin_i(grant_pin), .radio_hold_off_pin_i(rho_pin),
    .req_pin_i(req_wire), .req_pin_o(req_o), .req_pin_oe_o(req_oe),
    .pwm_req_pin_o(pwm_o), .pwm_req_pin_oe_o(pwm_oe), .pri_pin_o(pri_o),
    .dir_pri_pin_o(dir_o), .dir_pri_pin_oe_o(dir_oe), .ack_send_o(ack_send));
  rcx_pta_model #(.MS_CYC(MSC)) u_pta (.clk_i(clk), .sys_rst_i(rst),
    .act_hi_i(act_hi), .tmo_ms_i(tmo), .grant_cmd_i(grant_cmd),
    .rho_cmd_i(rho_cmd), .sib_req_i(sib_req), .req_o_i(req_o),
    .req_oe_i(req_oe), .grant_pin_o(grant_pin), .rho_pin_o(rho_pin),
    .req_wire_o(req_wire));
  task automatic print_verdict();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [33:0] seen, input logic [33:0] expv);
    n_compared++;
    if (seen !== expv) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask
  task automatic chk1(input logic seen, input logic expv);
    chk({33'h0, seen}, {33'h0, expv});
  endtask
  // Bus answers are taken off the queue in the cycle the handshake shows
  always @(negedge clk) begin
    if (ack_send === 1'b1) n_ack++;
    if (bvalid && bready) chk({bresp, 32'h0}, exp_q.pop_front());
    if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Handshakes are judged at the falling edge, since ready is registered
  task automatic axi(input bit wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] er, input logic [31:0] ed);
    bit ah, wh, rh, done;
    int n;
    exp_q.push_back(wr ? {er, 32'h0} : {er, ed});
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    done = 1'b0;
    n = 0;
    while (!done) begin
      @(negedge clk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      rh = arvalid && arready;
      done = (bvalid && bready) || (rvalid && rready);
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (rh) arvalid <= 1'b0;
      n++;
      if (n > 50) begin
        miscompares++;
        print_verdict();
      end
    end
    bready <= 1'b0;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    axi(1'b1, a, d, rcx_pkg::RESP_OKAY, 32'h0);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    axi(1'b0, a, 32'h0, rcx_pkg::RESP_OKAY, e);
  endtask
  task automatic set_ctrl(input logic [9:0] v);
    wr(rcx_pkg::OFS_CTRL, {22'h0, v});
    act_hi <= v[0];
    cyc(4);
  endtask
  task automatic pkt(input logic crc, input logic ack);
    rx_done <= 1'b1;
    crc_ok <= crc;
    ack_req <= ack;
    @(posedge clk);
    rx_done <= 1'b0;
  endtask
  initial begin
    void'($urandom(32'h9f46309d));
    cyc(6);
    rst <= 1'b0;
    cyc(2);
    rd(rcx_pkg::OFS_CTRL, 32'h0);
    rd(rcx_pkg::OFS_TMO, 32'h10);
    rd(rcx_pkg::OFS_PULSE, 32'h14);
    wr(rcx_pkg::OFS_PULSE, 32'h0);
    rd(rcx_pkg::OFS_PULSE, 32'h1);
    wr(rcx_pkg::OFS_PULSE, 32'hff);
    rd(rcx_pkg::OFS_PULSE, 32'hfe);
    wr(rcx_pkg::OFS_TMO, 32'hff);
    rd(rcx_pkg::OFS_TMO, 32'hff);
    axi(1'b1, 4'h2, 32'h1, rcx_pkg::RESP_SLVERR, 32'h0);
    axi(1'b0, 4'h2, 32'h0, rcx_pkg::RESP_SLVERR, 32'h0);
    wr(rcx_pkg::OFS_STAT, 32'hffff);
    $display("register test done");
    for (int k = 0; k < 2; k++) begin
      tmo = 8'(1 + $urandom % 3);
      wr(rcx_pkg::OFS_TMO, {24'h0, tmo});
      set_ctrl(RTEN | PRI | (k == 1 ? RTHI : 10'h0));
      pkt(1'b0, 1'b0);
      cyc(8);
      chk1(req_o, 1'b0);
      chk1(pri_o, k == 0);
      cyc(int'(tmo) * MSC - 8);
      chk1(req_o, 1'b0);
      cyc(6);
      chk1(req_o, 1'b1);
      pkt(1'b1, 1'b0);
      cyc(8);
      chk1(req_o, 1'b0);
      grant_cmd <= 1'b1;
      cyc(6);
      pkt(1'b1, 1'b0);
      cyc(6);
      chk1(req_o, 1'b1);
      grant_cmd <= 1'b0;
    end
    set_ctrl(PRI);
    pkt(1'b0, 1'b0);
    cyc(8);
    chk1(req_o, 1'b1);
    $display("retry hold test done");
    for (int i = 0; i < 7; i++) begin
      row = ROWS[i];
      set_ctrl((row[4] ? GATE : 10'h0) | (row[6] ? SHR : 10'h0));
      radio_req <= row[5];
      grant_cmd <= row[3];
      rho_cmd <= row[2];
      cyc(6);
      a0 = n_ack;
      pkt(row[1], 1'b1);
      cyc(4);
      chk1(n_ack == a0 + 1, row[0]);
    end
    grant_cmd <= 1'b0;
    rho_cmd <= 1'b0;
    $display("ack gating test done");
    for (int p = 0; p < 2; p++) begin
      set_ctrl(PRI | (p == 1 ? PWMP : 10'h0));
      pwm_req <= 1'b1;
      cyc(5);
      chk1(pri_o, p == 0);
      pwm_req <= 1'b0;
      cyc(4);
    end
    for (int s = 0; s < 2; s++) begin
      set_ctrl(SHR | 10'(s));
      cyc(2);
      chk1(req_oe, 1'b0);
      sib_req <= 1'b1;
      cyc(2);
      chk1(req_wire, s[0]);
      sib_req <= 1'b0;
      radio_req <= 1'b1;
      pwm_req <= 1'b1;
      cyc(4);
      chk1(req_oe, 1'b1);
      chk1(req_wire, s[0]);
      chk1(pwm_oe, 1'b1);
      chk1(pwm_o, s[0]);
      radio_req <= 1'b0;
      pwm_req <= 1'b0;
      cyc(4);
    end
    $display("pwm and shared test done");
    wr(rcx_pkg::OFS_PULSE, 32'h1);
    for (int t = 0; t < 2; t++) begin
      set_ctrl(DIR | PRI | TXHI);
      radio_tx <= t[0];
      lna <= !t[0];
      radio_req <= 1'b1;
      cyc(6);
      chk1(dir_o, !t[0]);
      chk1(pri_o, 1'b1);
      cyc(26);
      chk1(dir_o, t[0]);
      chk1(dir_oe, 1'b1);
      radio_tx <= !t[0];
      lna <= t[0];
      cyc(4);
      chk1(dir_o, !t[0]);
      radio_req <= 1'b0;
      cyc(6);
    end
    $display("directional test done");
    print_verdict();
  end
endmodule
`default_nettype wire
